// ---- rtl/wdt_pkg.sv ----
// Shared constants and types for the hardware watchdog block
package wdt_pkg;

	// ****************************************
	// Special function register map
	// ****************************************
	// Byte address of the refresh/flag register
	localparam logic [7:0] SFR_WDT_ADDR = 8'he8;
	// Field positions inside the register byte
	localparam int REFRESH_BIT = 7;
	localparam int RTC_FLAG_BIT = 1;
	localparam int XFER_FLAG_BIT = 0;
	// Reset value of every sticky flag
	localparam logic FLAG_RESET = 1'b0;
	// Read value for unmapped addresses and write-only bits
	localparam logic [7:0] SFR_IDLE_DATA = 8'h00;

	// ****************************************
	// Timing
	// ****************************************
	// System clock rate in hertz
	localparam int CLK_FREQ_HZ = 250000000;
	// Watchdog period in milliseconds
	localparam int WDT_TIMEOUT_MS = 1500;
	// Period in clock cycles, exact at this rate
	localparam int WDT_TIMEOUT_CYCLES = WDT_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
	// Counter width, enough for the full period
	localparam int CNT_W = 29;
	// Cycles the core stays in reset after a bite
	localparam logic [3:0] CORE_RST_CYCLES = 4'h8;
	localparam logic [3:0] HOLD_ZERO = 4'h0;

	// ****************************************
	// Types
	// ****************************************
	// Watchdog phase
	typedef enum logic {
		ST_COUNT,
		ST_HOLD
	} wd_state_e;

	// One access on the special function register port
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} sfr_req_s;

endpackage

// ---- rtl/irq_flag_bit.sv ----
// One sticky interrupt flag with set-over-clear priority
`timescale 1ns/1ns
module irq_flag_bit
	import wdt_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Controls
	input wire logic sync_clr_in,
	input wire logic set_in,
	input wire logic clr_in,
	// Flag state
	output logic flag_out
);

	// ****************************************
	// Flag storage
	// ****************************************
	// Set beats clear so an event is never lost
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_out <= FLAG_RESET;
		end else if (set_in) begin
			flag_out <= 1'b1;
		end else if (clr_in || sync_clr_in) begin
			flag_out <= FLAG_RESET;
		end
	end

endmodule

// ---- rtl/hw_watchdog_overflow_flag.sv ----
// Fixed-period hardware watchdog with overflow flag and irq flags
//
// Contract
// - Refresh by bit 7 write within 1.5 s
// - Overflow resets core like external reset
// - Overflow sets the watchdog overflow flag
// - Only external reset clears overflow flag
// - Fixed timeout, firmware cannot disable it
// - Refresh register sits at SFR address 0xE8
// - Same byte holds and clears irq flags
`timescale 1ns/1ns
module hw_watchdog_overflow_flag
	import wdt_pkg::*;
#(
	// Full period in cycles; shorten for simulation
	parameter int TIMEOUT_CYCLES = WDT_TIMEOUT_CYCLES
) (
	// Clock and external reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Special function register port
	input wire sfr_req_s sfr_req_in,
	output logic [7:0] sfr_rdata_out,
	// Interrupt events from the RTC and transfer logic
	input wire logic rtc_event_in,
	input wire logic transfer_event_in,
	// Flag state seen by firmware and interrupt logic
	output logic watchdog_overflow_flag_out,
	output logic rtc_irq_flag_out,
	output logic transfer_irq_flag_out,
	// Reset to the processor core
	output logic core_reset_n_out
);

	// ****************************************
	// Local constants
	// ****************************************
	// Last count before the watchdog bites
	localparam logic [CNT_W-1:0] TIMEOUT_LAST =
		CNT_W'(TIMEOUT_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	// ****************************************
	// Reset release synchroniser
	// ****************************************
	logic rst_meta_reg; // First stage, read only by second
	logic rst_n; // Released copy used everywhere

	// Assert at once, release after two clean edges
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// ****************************************
	// Register decode
	// ****************************************
	logic hit; // Access addresses the watchdog byte
	logic wr_hit; // Write to the watchdog byte
	logic refresh; // Firmware kicks the watchdog
	logic rtc_clr; // Firmware clears the RTC flag
	logic xfer_clr; // Firmware clears the transfer flag
	logic biting; // Core held in watchdog reset

	// Only the one documented address is decoded
	always_comb begin
		if (sfr_req_in.addr == SFR_WDT_ADDR) begin
			hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
	end

	// Whole-byte writes assumed; each bit acts on its own
	assign wr_hit = hit && sfr_req_in.wr;
	// Kicks while the core is in reset are meaningless
	assign refresh = wr_hit && sfr_req_in.wdata[REFRESH_BIT] && !biting;
	// Writing a one clears, so a refresh byte of 0x80 keeps flags
	assign rtc_clr = wr_hit && sfr_req_in.wdata[RTC_FLAG_BIT];
	assign xfer_clr = wr_hit && sfr_req_in.wdata[XFER_FLAG_BIT];

	// ****************************************
	// Watchdog counter and state
	// ****************************************
	wd_state_e state_reg; // Counting or holding the core
	logic [CNT_W-1:0] count_reg; // Cycles since last kick
	logic [3:0] hold_reg; // Remaining core-reset cycles
	logic overflow; // Period ran out this cycle

	assign biting = (state_reg == ST_HOLD);
	// No enable term: nothing firmware writes can stop it
	assign overflow = !biting && !refresh && (count_reg == TIMEOUT_LAST);

	// Phase of the watchdog
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_COUNT;
		end else begin
			case (state_reg)
				ST_COUNT: begin
					if (overflow) begin
						state_reg <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (hold_reg == CNT_ONE[3:0]) begin
						state_reg <= ST_COUNT;
					end
				end
				default: begin
					state_reg <= ST_COUNT;
				end
			endcase
		end
	end

	// Period counter, restarts on kick and on any reset
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= CNT_ZERO;
		end else if (biting || overflow) begin
			count_reg <= CNT_ZERO;
		end else if (refresh) begin
			count_reg <= CNT_ZERO;
		end else begin
			count_reg <= count_reg + CNT_ONE;
		end
	end

	// Core-reset stretch so the core sees a clean pulse
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			hold_reg <= HOLD_ZERO;
		end else if (overflow) begin
			hold_reg <= CORE_RST_CYCLES;
		end else if (hold_reg != HOLD_ZERO) begin
			hold_reg <= hold_reg - 4'h1;
		end
	end

	// Same low level as the pin, so the core cannot tell them apart
	assign core_reset_n_out = rst_n && !biting;

	// ****************************************
	// Overflow flag
	// ****************************************
	// Cleared only by the external pin; a bite leaves it set
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_overflow_flag_out <= FLAG_RESET;
		end else if (overflow) begin
			watchdog_overflow_flag_out <= 1'b1;
		end
	end

	// ****************************************
	// Interrupt flags sharing the byte
	// ****************************************
	// RTC event flag; the bite clears it like any core reset
	irq_flag_bit u_rtc_flag (
		.clk_in(sys_clk_in),
		.rst_n_in(rst_n),
		.sync_clr_in(biting),
		.set_in(rtc_event_in),
		.clr_in(rtc_clr),
		.flag_out(rtc_irq_flag_out)
	);

	// Transfer-complete event flag
	irq_flag_bit u_xfer_flag (
		.clk_in(sys_clk_in),
		.rst_n_in(rst_n),
		.sync_clr_in(biting),
		.set_in(transfer_event_in),
		.clr_in(xfer_clr),
		.flag_out(transfer_irq_flag_out)
	);

	// ****************************************
	// Read data
	// ****************************************
	// Registered read; refresh bit is write-only and reads zero
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata_out <= SFR_IDLE_DATA;
		end else if (sfr_req_in.rd && hit) begin
			sfr_rdata_out <= SFR_IDLE_DATA;
			sfr_rdata_out[RTC_FLAG_BIT] <= rtc_irq_flag_out;
			sfr_rdata_out[XFER_FLAG_BIT] <= transfer_irq_flag_out;
		end else begin
			// Unmapped or idle cycles answer zero
			sfr_rdata_out <= SFR_IDLE_DATA;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	// A kick restarts the period
	a_refresh_restart: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		refresh |=> (count_reg == CNT_ZERO) && !biting)
		else $error("kick did not restart the counter");

	// Running out of time enters reset
	a_overflow_bite: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		(!biting && !refresh && count_reg == TIMEOUT_LAST)
		|=> biting && watchdog_overflow_flag_out)
		else $error("timeout did not bite");

	// Core held low for exactly eight cycles
	a_core_reset_len: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		overflow |=> !core_reset_n_out [*8] ##1 core_reset_n_out)
		else $error("core reset pulse has wrong length");

	// Overflow flag follows a bite
	a_flag_set: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		$rose(biting) |-> watchdog_overflow_flag_out)
		else $error("overflow flag not set on bite");

	// Flag survives everything but the pin
	a_flag_sticky: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		watchdog_overflow_flag_out |=> watchdog_overflow_flag_out)
		else $error("overflow flag dropped without pin reset");

	// Counter keeps running without a kick
	a_no_disable: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		(!biting && !refresh && count_reg != TIMEOUT_LAST)
		|=> count_reg == $past(count_reg) + CNT_ONE)
		else $error("counter stalled without a kick");

	// Writes elsewhere do not kick
	a_addr_decode: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		(sfr_req_in.wr && sfr_req_in.addr != SFR_WDT_ADDR && !biting
		&& count_reg != TIMEOUT_LAST) |=> count_reg != CNT_ZERO)
		else $error("foreign address restarted the watchdog");

	// Event beats a clear in the same cycle
	a_irq_set_wins: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		rtc_event_in |=> rtc_irq_flag_out)
		else $error("rtc event lost");

	// Clear write drops the transfer flag
	a_irq_clear: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		(xfer_clr && !transfer_event_in) |=> !transfer_irq_flag_out)
		else $error("transfer flag not cleared by write");

	// Fresh full period after the bite ends
	a_restart_zero: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		$fell(biting) |-> count_reg == CNT_ZERO)
		else $error("counter not zero after watchdog reset");

endmodule

// ---- tb/test_hw_watchdog_overflow_flag.sv ----
// Self-checking bench for the hardware watchdog block
`timescale 1ns/1ns
module test_hw_watchdog_overflow_flag;
	import wdt_pkg::*;
	// Short period keeps the run brief
	localparam int T = 50;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	sfr_req_s req = '0;
	logic rtc_ev = 1'b0;
	logic xfer_ev = 1'b0;
	logic [7:0] rdata;
	logic ovf, rtc_f, xfer_f, core_n;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;

	// ****************************************
	// Design and clock
	// ****************************************
	hw_watchdog_overflow_flag #(.TIMEOUT_CYCLES(T)) dut_u (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.sfr_req_in(req),
		.sfr_rdata_out(rdata),
		.rtc_event_in(rtc_ev),
		.transfer_event_in(xfer_ev),
		.watchdog_overflow_flag_out(ovf),
		.rtc_irq_flag_out(rtc_f),
		.transfer_irq_flag_out(xfer_f),
		.core_reset_n_out(core_n)
	);
	always #2 sys_clk_in = ~sys_clk_in;
	// Hang guard, far above the expected run length
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			finish_test();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	// Inputs always change 1 ns after the rising edge
	task tick(input int k);
		repeat (k) @(posedge sys_clk_in);
		#1;
	endtask
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask
	// Idle edge after each strobe so it is never set twice in one step
	task sfr_wr(input logic [7:0] a, input logic [7:0] d);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		tick(1);
		req.wr = 1'b0;
		tick(1);
	endtask
	task sfr_rd(input logic [7:0] a, input logic [7:0] exp, input string w);
		req.addr = a;
		req.rd = 1'b1;
		tick(1);
		req.rd = 1'b0;
		chk(w, exp, rdata);
		tick(1);
	endtask
	task do_reset;
		rst_n_in = 1'b0;
		tick(20);
		rst_n_in = 1'b1;
		tick(3);
	endtask
	// Core must stay up k cycles, then fall exactly m edges later
	task expect_bite(input int k, input int m);
		tick(k);
		chk("core_up", 8'h01, {7'h00, core_n});
		n = 0;
		while (core_n !== 1'b0 && n < 6) begin
			tick(1);
			n++;
		end
		chk("core_down", 8'h00, {7'h00, core_n});
		chk("bite_time", 8'(m), 8'(n));
		chk("ovf_set", 8'h01, {7'h00, ovf});
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset_vals;
		chk("flags", 8'h01, {4'h0, ovf, rtc_f, xfer_f, core_n});
		sfr_rd(8'he8, 8'h00, "rd_e8");
		sfr_rd(8'he9, SFR_IDLE_DATA, "rd_unmapped");
	endtask
	// Flags set by events, RTC cleared alone then both together by byte writes
	task t_flags;
		sfr_wr(8'he8, 8'h80);
		rtc_ev = 1'b1;
		tick(1);
		rtc_ev = 1'b0;
		xfer_ev = 1'b1;
		tick(1);
		xfer_ev = 1'b0;
		tick(1);
		sfr_rd(8'he8, 8'h03, "rd_both");
		sfr_rd(8'he9, SFR_IDLE_DATA, "rd_unmapped_set");
		sfr_wr(8'he9, 8'h03);
		sfr_wr(8'he8, 8'h80);
		sfr_rd(8'he8, 8'h03, "rd_kept");
		sfr_wr(8'he8, 8'h02);
		chk("rtc_clr", 8'h01, {6'h00, rtc_f, xfer_f});
		// Event and clear in one cycle: the event must win
		req.addr = 8'he8;
		req.wdata = 8'h02;
		req.wr = 1'b1;
		rtc_ev = 1'b1;
		tick(1);
		req.wr = 1'b0;
		rtc_ev = 1'b0;
		tick(1);
		chk("rtc_set_wins", 8'h01, {7'h00, rtc_f});
		sfr_wr(8'he8, 8'h03);
		sfr_rd(8'he8, 8'h00, "rd_none");
	endtask
	// Regular refresh keeps the core running across many periods
	task t_kick;
		for (int i = 0; i < 6; i++) begin
			sfr_wr(8'he8, 8'h80);
			tick(T - 8);
			chk("core_kept", 8'h01, {7'h00, core_n});
		end
	endtask
	// Missed refresh bites; flag survives its own reset
	task t_bite;
		sfr_wr(8'he8, 8'h80);
		rtc_ev = 1'b1;
		tick(1);
		rtc_ev = 1'b0;
		sfr_wr(8'he9, 8'h80);
		expect_bite(T - 7, 3);
		n = 0;
		while (core_n !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		chk("hold_len", 8'(CORE_RST_CYCLES), 8'(n));
		chk("rtc_cleared", 8'h00, {7'h00, rtc_f});
		chk("ovf_kept", 8'h01, {7'h00, ovf});
		expect_bite(T - 3, 3);
		tick(12);
		chk("ovf_still", 8'h01, {7'h00, ovf});
		do_reset();
		chk("ovf_pin_clr", 8'h00, {7'h00, ovf});
		expect_bite(T - 6, 5);
	endtask

	// ****************************************
	// Run and verdict
	// ****************************************
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#1;
		do_reset();
		t_reset_vals();
		t_flags();
		t_kick();
		t_bite();
		finish_test();
	end
endmodule
